// file: verilog/sl2_pkg.sv
// Shared types and constants for the signalling link level 2 control slice
package sl2_pkg;

  // ****************************************************************
  // Status indications
  // ****************************************************************
  typedef enum logic [2:0] {
    SI_OUT_ALIGN  = 3'h0,
    SI_NORMAL     = 3'h1,
    SI_EMERGENCY  = 3'h2,
    SI_OUT_SVC    = 3'h3,
    SI_PROC_OUT   = 3'h4,
    SI_BUSY       = 3'h5
  } status_ind_t;

  localparam int STATUS_LSB   = 0;
  localparam int STATUS_W     = 3;
  localparam logic [5:0] LI_STATUS_ONE = 6'h01;
  localparam logic [5:0] LI_STATUS_TWO = 6'h02;

  // ****************************************************************
  // Transmit item selection
  // ****************************************************************
  typedef enum logic [2:0] {
    ITEM_FLAG,
    ITEM_FILL,
    ITEM_STATUS,
    ITEM_NEW_MSG,
    ITEM_RETX_MSG
  } tx_item_t;

  typedef struct packed {
    logic status;
    logic nacked;
    logic forced;
    logic new_msg;
    logic unacked;
    logic repeat_msg;
  } tx_pending_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ       = 250_000_000;
  localparam longint TICK_US      = 1000;
  localparam int     TICK_CYCLES  = int'(CLK_HZ / 1_000_000 * TICK_US);
  localparam int     TICK_CNT_W   = 18;
  localparam int     TMR_W        = 20;

  // Limits in milliseconds; timer ticks are one millisecond
  localparam logic [TMR_W-1:0] T1_64_MIN_MS   = 20'd40000;
  localparam logic [TMR_W-1:0] T1_64_MAX_MS   = 20'd50000;
  localparam logic [TMR_W-1:0] T1_48_MIN_MS   = 20'd500000;
  localparam logic [TMR_W-1:0] T1_48_MAX_MS   = 20'd600000;
  localparam logic [TMR_W-1:0] T2_MIN_MS      = 20'd5000;
  localparam logic [TMR_W-1:0] T2_MAX_MS      = 20'd150000;
  localparam logic [TMR_W-1:0] T2_LOW_MAX_MS  = 20'd50000;
  localparam logic [TMR_W-1:0] T2_HIGH_MIN_MS = 20'd70000;
  localparam logic [TMR_W-1:0] T3_MIN_MS      = 20'd1000;
  localparam logic [TMR_W-1:0] T3_MAX_MS      = 20'd2000;
  localparam logic [TMR_W-1:0] T4N_64_MIN_MS  = 20'd7500;
  localparam logic [TMR_W-1:0] T4N_64_MAX_MS  = 20'd9500;
  localparam logic [TMR_W-1:0] T4N_48_MIN_MS  = 20'd100000;
  localparam logic [TMR_W-1:0] T4N_48_MAX_MS  = 20'd120000;
  localparam logic [TMR_W-1:0] T4E_64_MIN_MS  = 20'd400;
  localparam logic [TMR_W-1:0] T4E_64_MAX_MS  = 20'd600;
  localparam logic [TMR_W-1:0] T4E_48_MIN_MS  = 20'd6000;
  localparam logic [TMR_W-1:0] T4E_48_MAX_MS  = 20'd8000;
  localparam logic [TMR_W-1:0] T4N_64_NOM_MS  = 20'd8200;
  localparam logic [TMR_W-1:0] T4N_48_NOM_MS  = 20'd110000;
  localparam logic [TMR_W-1:0] T4E_64_NOM_MS  = 20'd500;
  localparam logic [TMR_W-1:0] T4E_48_NOM_MS  = 20'd7000;
  localparam logic [TMR_W-1:0] T5_MIN_MS      = 20'd80;
  localparam logic [TMR_W-1:0] T5_MAX_MS      = 20'd120;
  localparam logic [TMR_W-1:0] T6_64_MIN_MS   = 20'd3000;
  localparam logic [TMR_W-1:0] T6_64_MAX_MS   = 20'd6000;
  localparam logic [TMR_W-1:0] T6_48_MIN_MS   = 20'd8000;
  localparam logic [TMR_W-1:0] T6_48_MAX_MS   = 20'd12000;
  localparam logic [TMR_W-1:0] T7_64_MIN_MS   = 20'd500;
  localparam logic [TMR_W-1:0] T7_64_MAX_MS   = 20'd2000;
  localparam logic [TMR_W-1:0] T7_48_MIN_MS   = 20'd4000;
  localparam logic [TMR_W-1:0] T7_48_MAX_MS   = 20'd6000;
  localparam logic [TMR_W-1:0] T7_CYCLIC_MIN_MS = 20'd800;

  // Timer indices
  localparam int NUM_TMR = 7;
  localparam int T1_IDX = 0;
  localparam int T2_IDX = 1;
  localparam int T3_IDX = 2;
  localparam int T4_IDX = 3;
  localparam int T5_IDX = 4;
  localparam int T6_IDX = 5;
  localparam int T7_IDX = 6;

  // Sequence numbering and retransmission limits
  localparam int SEQ_W    = 7;
  localparam int N1_MAX   = 127;
  localparam int OCT_W    = 16;

endpackage : sl2_pkg

// file: verilog/sl2_timer.sv
// One supervision timer counting millisecond ticks with clamped setting
`timescale 1ns/1ps
`default_nettype none
module sl2_timer
  import sl2_pkg::*;
(
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_tick,
  input  wire logic             i_start,
  input  wire logic             i_stop,
  input  wire logic [TMR_W-1:0] i_set,
  input  wire logic [TMR_W-1:0] i_min,
  input  wire logic [TMR_W-1:0] i_max,
  output logic                  o_run,
  output logic                  o_expired
);

  typedef struct packed {
    logic             run;
    logic             expired;
    logic [TMR_W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;
  logic [TMR_W-1:0] load;

  always_comb
  begin
    // Out-of-range settings are clamped, so a bad setting never disables a timer
    if (i_set < i_min)
      load = i_min;
    else if (i_set > i_max)
      load = i_max;
    else
      load = i_set;
    s_nxt         = s_r;
    s_nxt.expired = 1'b0;
    if (i_stop)
    begin
      s_nxt.run = 1'b0;
    end
    else if (i_start)
    begin
      s_nxt.run = 1'b1;
      s_nxt.cnt = load;
    end
    else if (s_r.run && i_tick)
    begin
      if (s_r.cnt <= TMR_W'(1))
      begin
        s_nxt.run     = 1'b0;
        s_nxt.expired = 1'b1;
        s_nxt.cnt     = '0;
      end
      else
        s_nxt.cnt = s_r.cnt - TMR_W'(1);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_run     = s_r.run;
  assign o_expired = s_r.expired;

endmodule // sl2_timer
`default_nettype wire

// file: verilog/sl2_tx_select.sv
// Priority selection of the next transmitted item
`timescale 1ns/1ps
`default_nettype none
module sl2_tx_select
  import sl2_pkg::*;
(
  input  wire logic        i_cyclic,
  input  wire logic        i_repeat_en,
  input  wire tx_pending_t i_pend,
  output tx_item_t         o_item
);

  always_comb
  begin
    if (i_pend.status)
      o_item = ITEM_STATUS;
    else if (!i_cyclic && i_repeat_en && i_pend.repeat_msg)
      o_item = ITEM_RETX_MSG;
    else if (!i_cyclic && i_pend.nacked)
      o_item = ITEM_RETX_MSG;
    else if (i_cyclic && i_pend.forced)
      o_item = ITEM_RETX_MSG;
    else if (i_pend.new_msg)
      o_item = ITEM_NEW_MSG;
    else if (i_cyclic && i_pend.unacked)
      o_item = ITEM_RETX_MSG;
    else if (i_pend.unacked || i_pend.new_msg || 1'b1)
      o_item = ITEM_FILL;
    else
      o_item = ITEM_FLAG;
  end

endmodule // sl2_tx_select
`default_nettype wire

// file: verilog/sl2_link_ctrl.sv
// Signalling link level 2 status coding, transmit priority and timers
`timescale 1ns/1ps
`default_nettype none
module sl2_link_ctrl
  import sl2_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // Link rate and method
  input  wire logic              i_rate_low,
  input  wire logic              i_cyclic,
  input  wire logic              i_repeat_en,
  input  wire logic              i_auto_alloc,
  input  wire logic              i_t2_high,
  input  wire logic              i_proving_emerg,
  input  wire logic              i_latch_po_en,
  input  wire logic              i_oos_on_resync,
  // Timer settings in milliseconds
  input  wire logic [TMR_W-1:0]  i_t_set [NUM_TMR],
  // Timer start and stop controls from link state logic
  input  wire logic [NUM_TMR-1:0] i_t_start,
  input  wire logic [NUM_TMR-1:0] i_t_stop,
  // Status to send and receive
  input  wire logic              i_tx_status_req,
  input  wire status_ind_t       i_tx_status,
  input  wire logic              i_rx_valid,
  input  wire logic [5:0]        i_rx_li,
  input  wire logic [7:0]        i_rx_sf0,
  input  wire logic [7:0]        i_rx_sf1,
  // Congestion and outage
  input  wire logic              i_congested,
  input  wire logic              i_po_local,
  input  wire logic              i_po_l3,
  input  wire logic              i_resync_req,
  // Transmit queue state
  input  wire logic              i_su_boundary,
  input  wire tx_pending_t       i_pend,
  input  wire logic [SEQ_W-1:0]  i_rtb_count,
  input  wire logic [OCT_W-1:0]  i_rtb_octets,
  input  wire logic [SEQ_W-1:0]  i_n1,
  input  wire logic [OCT_W-1:0]  i_n2,
  input  wire logic [SEQ_W-1:0]  i_fsn_expected,
  // Outputs
  output tx_item_t               o_tx_item,
  output logic                   o_tx_item_valid,
  output logic [7:0]             o_tx_sf,
  output logic [SEQ_W-1:0]       o_tx_bsn,
  output logic                   o_rx_status_valid,
  output status_ind_t            o_rx_status,
  output logic                   o_rx_status_bad,
  output logic                   o_po_active,
  output logic                   o_link_fail,
  output logic                   o_out_of_service,
  output logic                   o_flush_resync,
  output logic [NUM_TMR-1:0]     o_t_run,
  output logic [NUM_TMR-1:0]     o_t_expired
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic                  tick;
    tx_item_t              tx_item;
    logic                  tx_item_valid;
    logic [7:0]            tx_sf;
    logic [SEQ_W-1:0]      tx_bsn;
    logic                  rx_status_valid;
    status_ind_t           rx_status;
    logic                  rx_status_bad;
    logic                  busy_seen;
    logic                  busy_due;
    logic                  po_latched;
    logic                  link_fail;
    logic                  oos;
    logic                  flush;
    logic                  cong_prev;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;

  logic [TMR_W-1:0]   t_min [NUM_TMR];
  logic [TMR_W-1:0]   t_max [NUM_TMR];
  logic [NUM_TMR-1:0] t_start;
  logic [NUM_TMR-1:0] t_stop;
  logic [NUM_TMR-1:0] t_run;
  logic [NUM_TMR-1:0] t_exp;
  tx_pending_t        pend;
  tx_item_t           sel_item;
  logic               over_limit;
  logic               rx_is_status;
  logic               rx_busy;

  // ****************************************************************
  // Timer ranges by rate and method
  // ****************************************************************
  always_comb
  begin
    t_min[T1_IDX] = i_rate_low ? T1_48_MIN_MS : T1_64_MIN_MS;
    t_max[T1_IDX] = i_rate_low ? T1_48_MAX_MS : T1_64_MAX_MS;
    t_min[T2_IDX] = T2_MIN_MS;
    t_max[T2_IDX] = T2_MAX_MS;
    if (i_auto_alloc)
    begin
      t_min[T2_IDX] = i_t2_high ? T2_HIGH_MIN_MS : T2_MIN_MS;
      t_max[T2_IDX] = i_t2_high ? T2_MAX_MS : T2_LOW_MAX_MS;
    end
    t_min[T3_IDX] = T3_MIN_MS;
    t_max[T3_IDX] = T3_MAX_MS;
    if (i_proving_emerg)
    begin
      t_min[T4_IDX] = i_rate_low ? T4E_48_MIN_MS : T4E_64_MIN_MS;
      t_max[T4_IDX] = i_rate_low ? T4E_48_MAX_MS : T4E_64_MAX_MS;
    end
    else
    begin
      t_min[T4_IDX] = i_rate_low ? T4N_48_MIN_MS : T4N_64_MIN_MS;
      t_max[T4_IDX] = i_rate_low ? T4N_48_MAX_MS : T4N_64_MAX_MS;
    end
    t_min[T5_IDX] = T5_MIN_MS;
    t_max[T5_IDX] = T5_MAX_MS;
    t_min[T6_IDX] = i_rate_low ? T6_48_MIN_MS : T6_64_MIN_MS;
    t_max[T6_IDX] = i_rate_low ? T6_48_MAX_MS : T6_64_MAX_MS;
    t_min[T7_IDX] = i_rate_low ? T7_48_MIN_MS : T7_64_MIN_MS;
    t_max[T7_IDX] = i_rate_low ? T7_48_MAX_MS : T7_64_MAX_MS;
    if (i_cyclic && !i_rate_low)
      t_min[T7_IDX] = T7_CYCLIC_MIN_MS;
  end

  // ****************************************************************
  // Timer controls: busy repeat and remote congestion driven here
  // ****************************************************************
  assign rx_is_status = i_rx_valid && (i_rx_li == LI_STATUS_ONE || i_rx_li == LI_STATUS_TWO);
  assign rx_busy      = rx_is_status && (status_ind_t'(i_rx_sf0[STATUS_LSB +: STATUS_W]) == SI_BUSY);

  always_comb
  begin
    t_start = i_t_start;
    t_stop  = i_t_stop;
    // Busy repeat timer starts when congestion begins and restarts at each expiry while congested
    t_start[T5_IDX] = (i_congested && !s_r.cong_prev) || (i_congested && t_exp[T5_IDX]);
    t_stop[T5_IDX]  = i_t_stop[T5_IDX] || !i_congested;
    t_start[T6_IDX] = i_t_start[T6_IDX] || (rx_busy && !s_r.busy_seen && (i_rtb_count != '0));
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++)
    begin : g_tmr
      sl2_timer u_tmr (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_tick    (s_r.tick),
        .i_start   (t_start[g]),
        .i_stop    (t_stop[g]),
        .i_set     (i_t_set[g]),
        .i_min     (t_min[g]),
        .i_max     (t_max[g]),
        .o_run     (t_run[g]),
        .o_expired (t_exp[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Transmit selection
  // ****************************************************************
  // Limit one is capped by the numbering capacity so it can never wrap
  assign over_limit = (i_rtb_count >= ((i_n1 > SEQ_W'(N1_MAX)) ? SEQ_W'(N1_MAX) : i_n1))
                    || (i_rtb_octets >= i_n2);

  always_comb
  begin
    pend        = i_pend;
    // Busy units stop in the very cycle congestion abates
    pend.status = i_pend.status || i_tx_status_req || (s_r.busy_due && i_congested);
    pend.forced = i_pend.unacked && over_limit;
  end

  sl2_tx_select u_sel (
    .i_cyclic    (i_cyclic),
    .i_repeat_en (i_repeat_en),
    .i_pend      (pend),
    .o_item      (sel_item)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1))
    begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick     = 1'b1;
    end
    else
      s_nxt.tick_cnt = s_r.tick_cnt + TICK_CNT_W'(1);

    s_nxt.cong_prev = i_congested;
    // A new busy due wins over the clear from the same boundary
    if (i_su_boundary && s_r.busy_due)
      s_nxt.busy_due = 1'b0;
    if (i_congested && (!s_r.cong_prev || t_exp[T5_IDX]))
      s_nxt.busy_due = 1'b1;
    if (!i_congested)
      s_nxt.busy_due = 1'b0;

    s_nxt.tx_item_valid = 1'b0;
    if (i_su_boundary)
    begin
      s_nxt.tx_item       = sel_item;
      s_nxt.tx_item_valid = 1'b1;
      s_nxt.tx_sf         = '0;
      s_nxt.tx_sf[STATUS_LSB +: STATUS_W] = (s_r.busy_due && i_congested) ? SI_BUSY : i_tx_status;
      s_nxt.tx_bsn        = i_fsn_expected - SEQ_W'(1);
    end

    s_nxt.rx_status_valid = 1'b0;
    if (rx_is_status)
    begin
      // Only bits C B A decode; the second octet is not looked at
      s_nxt.rx_status_valid = 1'b1;
      s_nxt.rx_status       = status_ind_t'(i_rx_sf0[STATUS_LSB +: STATUS_W]);
      s_nxt.rx_status_bad   = i_rx_sf0[STATUS_LSB +: STATUS_W] > SI_BUSY;
    end
    // A busy unit arriving with the stop still counts as seen
    if (i_t_stop[T6_IDX])
      s_nxt.busy_seen = 1'b0;
    if (rx_busy)
      s_nxt.busy_seen = 1'b1;

    if (i_po_local || (i_latch_po_en && i_po_l3))
      s_nxt.po_latched = 1'b1;
    else if (!i_latch_po_en)
      s_nxt.po_latched = 1'b0;

    s_nxt.link_fail = s_r.link_fail || t_exp[T6_IDX];
    s_nxt.flush     = i_resync_req && !i_oos_on_resync;
    s_nxt.oos       = s_r.oos || (i_resync_req && i_oos_on_resync);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_t_run     <= '0;
      o_t_expired <= '0;
    end
    else
    begin
      o_t_run     <= t_run;
      o_t_expired <= t_exp;
    end
  end

  assign o_tx_item         = s_r.tx_item;
  assign o_tx_item_valid   = s_r.tx_item_valid;
  assign o_tx_sf           = s_r.tx_sf;
  assign o_tx_bsn          = s_r.tx_bsn;
  assign o_rx_status_valid = s_r.rx_status_valid;
  assign o_rx_status       = s_r.rx_status;
  assign o_rx_status_bad   = s_r.rx_status_bad;
  assign o_po_active       = s_r.po_latched;
  assign o_link_fail       = s_r.link_fail;
  assign o_out_of_service  = s_r.oos;
  assign o_flush_resync    = s_r.flush;

endmodule // sl2_link_ctrl
`default_nettype wire

// file: verif/sl2_link_monitor.sv
// Port checks for the level 2 control slice
`timescale 1ns/1ps
`default_nettype none
module sl2_link_monitor
  import sl2_pkg::*;
(
  input wire logic               i_mclk,
  input wire logic               i_rst,
  input wire logic               i_cyclic,
  input wire logic [NUM_TMR-1:0] i_t_start,
  input wire logic [NUM_TMR-1:0] i_t_stop,
  input wire logic               i_tx_status_req,
  input wire status_ind_t        i_tx_status,
  input wire logic               i_rx_valid,
  input wire logic [5:0]         i_rx_li,
  input wire logic [7:0]         i_rx_sf0,
  input wire logic               i_congested,
  input wire logic               i_su_boundary,
  input wire tx_pending_t        i_pend,
  input wire logic [SEQ_W-1:0]   i_fsn_expected,
  input wire tx_item_t           o_tx_item,
  input wire logic               o_tx_item_valid,
  input wire logic [7:0]         o_tx_sf,
  input wire logic [SEQ_W-1:0]   o_tx_bsn,
  input wire logic               o_rx_status_valid,
  input wire status_ind_t        o_rx_status,
  input wire logic [NUM_TMR-1:0] o_t_run
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // No status or busy unit competes for the slot
  wire logic quiet = !i_tx_status_req && !i_congested && !i_pend.status;
  wire logic li_ok = (i_rx_li == LI_STATUS_ONE) || (i_rx_li == LI_STATUS_TWO);

  property p_rx_code;
    i_rx_valid && li_ok |=> o_rx_status_valid && {5'h00, o_rx_status} == ($past(i_rx_sf0) & 8'h07);
  endproperty
  a_rx_code: assert property (p_rx_code) else $error("rx code wrong");
  property p_rx_skip; i_rx_valid && !li_ok |=> !o_rx_status_valid; endproperty
  a_rx_skip: assert property (p_rx_skip) else $error("rx unit not skipped");
  property p_valid; o_tx_item_valid == $past(i_su_boundary); endproperty
  a_valid: assert property (p_valid) else $error("item valid wrong");
  property p_status;
    i_su_boundary && i_tx_status_req && !i_congested |=> o_tx_item == ITEM_STATUS && o_tx_sf[2:0] == $past(i_tx_status);
  endproperty
  a_status: assert property (p_status) else $error("status not first");
  property p_bsn; i_su_boundary |=> o_tx_bsn == $past(i_fsn_expected) - 7'h01; endproperty
  a_bsn: assert property (p_bsn) else $error("bsn wrong");
  property p_nack; i_su_boundary && quiet && !i_cyclic && i_pend.nacked |=> o_tx_item == ITEM_RETX_MSG; endproperty
  a_nack: assert property (p_nack) else $error("nacked unit not sent");
  property p_fill; i_su_boundary && quiet && (i_pend & 6'h37) == 6'h00 |=> o_tx_item == ITEM_FILL; endproperty
  a_fill: assert property (p_fill) else $error("fill not sent");
  property p_t1; i_t_start[T1_IDX] && !i_t_stop[T1_IDX] |-> ##[1:3] o_t_run[T1_IDX]; endproperty
  a_t1: assert property (p_t1) else $error("timer not started");
  property p_t5; $rose(i_congested) |-> ##[1:3] o_t_run[T5_IDX]; endproperty
  a_t5: assert property (p_t5) else $error("busy timer idle");
endmodule // sl2_link_monitor
`default_nettype wire

// file: verif/sl2_remote_term.sv
// Remote terminal model sending status units
`timescale 1ns/1ps
`default_nettype none
module sl2_remote_term (
  input  wire logic       i_mclk,
  input  wire logic       i_send,
  input  wire logic [2:0] i_code,
  input  wire logic [5:0] i_li,
  input  wire logic [4:0] i_spare,
  output logic            o_rx_valid,
  output logic [5:0]      o_rx_li,
  output logic [7:0]      o_rx_sf0,
  output logic [7:0]      o_rx_sf1
);
  initial
  begin
    {o_rx_valid, o_rx_li, o_rx_sf0, o_rx_sf1} = '0;
  end
  // Lines toggle outside a unit so stale values never pass
  always @(posedge i_mclk)
  begin
    o_rx_valid <= i_send;
    o_rx_li    <= i_send ? i_li : ~o_rx_li;
    o_rx_sf0   <= i_send ? {i_spare, i_code} : ~o_rx_sf0;
    o_rx_sf1   <= ~o_rx_sf1;
  end
endmodule // sl2_remote_term
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the level 2 control slice
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sl2_pkg::*;
  logic               mclk = 1'b0;
  logic               rst, rate_low, cyclic, rep_en, auto_al, t2_high, emerg, latch_po, oos_rs;
  logic [TMR_W-1:0]   t_set [NUM_TMR];
  logic [NUM_TMR-1:0] t_start, t_stop, t_run, t_exp;
  logic               st_req, congested, po_local, po_l3, resync, su_b, send, over, pick, seen;
  status_ind_t        st_code, rx_status;
  tx_pending_t        pend;
  logic [SEQ_W-1:0]   rtb_cnt, n1, fsn, bsn;
  logic [OCT_W-1:0]   rtb_oct, n2;
  logic [2:0]         code;
  logic [5:0]         li, rx_li;
  logic [4:0]         spare;
  logic [7:0]         sf0, sf1, tx_sf;
  logic               rx_valid, item_valid, rxs_valid, rxs_bad, po_act, link_fail, oos, flush;
  tx_item_t           item;
  int                 mismatches = 0;
  int                 cmp_count = 0;

  always #2 mclk = ~mclk;

  sl2_remote_term i_far (.i_mclk(mclk), .i_send(send), .i_code(code), .i_li(li), .i_spare(spare),
    .o_rx_valid(rx_valid), .o_rx_li(rx_li), .o_rx_sf0(sf0), .o_rx_sf1(sf1));
  sl2_link_ctrl i_dut (.i_mclk(mclk), .i_rst(rst), .i_rate_low(rate_low), .i_cyclic(cyclic),
    .i_repeat_en(rep_en), .i_auto_alloc(auto_al), .i_t2_high(t2_high), .i_proving_emerg(emerg),
    .i_latch_po_en(latch_po), .i_oos_on_resync(oos_rs), .i_t_set(t_set), .i_t_start(t_start),
    .i_t_stop(t_stop), .i_tx_status_req(st_req), .i_tx_status(st_code), .i_rx_valid(rx_valid),
    .i_rx_li(rx_li), .i_rx_sf0(sf0), .i_rx_sf1(sf1), .i_congested(congested), .i_po_local(po_local),
    .i_po_l3(po_l3), .i_resync_req(resync), .i_su_boundary(su_b), .i_pend(pend), .i_rtb_count(rtb_cnt),
    .i_rtb_octets(rtb_oct), .i_n1(n1), .i_n2(n2), .i_fsn_expected(fsn), .o_tx_item(item),
    .o_tx_item_valid(item_valid), .o_tx_sf(tx_sf), .o_tx_bsn(bsn), .o_rx_status_valid(rxs_valid),
    .o_rx_status(rx_status), .o_rx_status_bad(rxs_bad), .o_po_active(po_act), .o_link_fail(link_fail),
    .o_out_of_service(oos), .o_flush_resync(flush), .o_t_run(t_run), .o_t_expired(t_exp));

  // ****************
  // Helpers
  // ****************
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rx_unit(input logic [2:0] c, input logic [5:0] l);
    send = 1'b1;
    code = c;
    li = l;
    spare = 5'($urandom);
    step();
    send = 1'b0;
    step();
  endtask

  // Over-limit units only exist where unacked ones wait
  function automatic tx_item_t exp_item(input logic cyc, input logic rep, input tx_pending_t p, input logic ov);
    if (p.status)
      return ITEM_STATUS;
    if (cyc ? ov : ((rep && p.repeat_msg) || p.nacked))
      return ITEM_RETX_MSG;
    if (p.new_msg)
      return ITEM_NEW_MSG;
    if (cyc && p.unacked)
      return ITEM_RETX_MSG;
    return ITEM_FILL;
  endfunction

  // ****************
  // Sequence
  // ****************
  initial
  begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    void'($urandom(44239));
    rst = 1'b1;
    {rate_low, auto_al, t2_high, emerg} = 4'($urandom);
    {cyclic, rep_en, latch_po, oos_rs, st_req, congested, po_local, po_l3, resync, su_b, send} = '0;
    foreach (t_set[k]) t_set[k] = T5_MAX_MS;
    {t_start, t_stop, rtb_cnt, n1, fsn, rtb_oct, n2, code, li, spare} = '0;
    st_code = SI_OUT_ALIGN;
    pend = '0;
    step(2);
    rst = 1'b0;
    su_b = 1'b1;
    for (int k = 0; k < 240; k++)
    begin
      cyclic = 1'($urandom);
      rep_en = 1'($urandom);
      pend = tx_pending_t'(6'($urandom));
      st_req = ($urandom_range(0, 3) == 0);
      if (k % 16 == 0)
      begin
        pend = '0;
        st_req = 1'b0;
      end
      pend.forced = 1'b0;
      pend.status = st_req;
      if (cyclic)
      begin
        pend.nacked = 1'b0;
        pend.repeat_msg = 1'b0;
      end
      st_code = status_ind_t'($urandom_range(0, 5));
      over = cyclic && pend.unacked && 1'($urandom);
      pick = 1'($urandom);
      n1 = 7'($urandom_range(10, 110));
      n2 = 16'($urandom_range(256, 32768));
      rtb_cnt = (over && pick) ? n1 + 7'h05 : n1 - 7'h05;
      rtb_oct = (over && !pick) ? n2 + 16'h0010 : n2 - 16'h0010;
      fsn = (k % 16 == 0) ? 7'h00 : 7'($urandom);
      step();
      chk(32'(item_valid), 32'h1, "valid");
      chk(32'(item), 32'(exp_item(cyclic, rep_en, pend, over)), "item");
      chk(32'(bsn), 32'(7'(fsn - 7'h01)), "bsn");
      if (st_req)
        chk(32'(tx_sf[2:0]), 32'(st_code), "sf");
    end
    su_b = 1'b0;
    rtb_cnt = 7'h03;
    rx_unit(3'h5, 6'h01);
    step(2);
    chk(32'(t_run[T6_IDX]), 32'h1, "remote timer");
    for (int k = 0; k < 32; k++)
    begin
      rx_unit(3'(k), 6'(k / 8));
      chk(32'(rxs_valid), 32'(k / 8 == 1 || k / 8 == 2), "rx valid");
      if (k / 8 == 1 || k / 8 == 2)
      begin
        chk(32'(rx_status), 32'(k % 8), "rx code");
        chk(32'(rxs_bad), 32'(k % 8 > 5), "rx bad");
      end
    end
    t_start = 7'h6F;
    step();
    t_start = 7'h00;
    step(2);
    chk(32'(t_run & 7'h6F), 32'h6F, "timers run");
    t_start = 7'h01;
    t_stop = 7'h6F;
    step();
    {t_start, t_stop} = '0;
    step(2);
    chk(32'(t_run & 7'h6F), 32'h0, "timers stop");
    congested = 1'b1;
    step(3);
    chk(32'(t_run[T5_IDX]), 32'h1, "busy timer");
    su_b = 1'b1;
    step();
    su_b = 1'b0;
    chk(32'(item), 32'(ITEM_STATUS), "busy item");
    chk(32'(tx_sf[2:0]), 32'(SI_BUSY), "busy sf");
    congested = 1'b0;
    step(3);
    chk(32'(t_run[T5_IDX]), 32'h0, "busy stop");
    po_local = 1'b1;
    step(3);
    chk(32'(po_act), 32'h1, "po local");
    po_local = 1'b0;
    po_l3 = 1'b1;
    step(3);
    chk(32'(po_act), 32'h0, "po off");
    latch_po = 1'b1;
    step(3);
    chk(32'(po_act), 32'h1, "po on");
    resync = 1'b1;
    step();
    resync = 1'b0;
    seen = flush;
    step();
    chk(32'(seen | flush), 32'h1, "flush");
    chk(32'(oos), 32'h0, "in service");
    oos_rs = 1'b1;
    resync = 1'b1;
    step();
    resync = 1'b0;
    step();
    chk(32'(oos), 32'h1, "out of service");
    chk(32'(link_fail), 32'h0, "no link fail");
    chk(32'(t_exp), 32'h0, "no expiry");
    finish_test();
  end
endmodule // tb

bind sl2_link_ctrl sl2_link_monitor i_mon (.i_mclk, .i_rst, .i_cyclic, .i_t_start, .i_t_stop, .i_tx_status_req,
  .i_tx_status, .i_rx_valid, .i_rx_li, .i_rx_sf0, .i_congested, .i_su_boundary, .i_pend, .i_fsn_expected,
  .o_tx_item, .o_tx_item_valid, .o_tx_sf, .o_tx_bsn, .o_rx_status_valid, .o_rx_status, .o_t_run);
`default_nettype wire
